// *** hdl/mio_ports.sv ***
// analog input port, serial-shared port and bus-control port with AXI4-Lite registers
// What this block does
// - analog port input only, reads live pins
// - analog pins feed converter; top two analog outputs
// - analog register reset follows pin levels
// - serial port has seven pins, bits six-zero
// - direction one output; reset value top bit
// - serial registers top bit reads one, unwritable
// - serial read: latch if output, else pin
// - transmit function drives fifth pin, overriding
// - receive function takes sixth pin as input
// - clock function owns seventh pin, overriding
// - reset makes all serial pins inputs
// - hardware standby floats every serial pin
// - software standby reverts serial pins to gpio
// - lowest bus pins: gpio, interrupt, trigger
// - expanded mode: strobes out, wait in
// - bit six outputs system clock when expanded
// - bus direction reset depends on mode
// - bus data bit six read-only; others reset zero
// - expanded strobe pins ignore direction and data
// - single-chip bit six: direction selects clock
// - bus read: latch if output, else pin; bit six always pin
// - expanded reset: low pins in, upper functions
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module mio_ports import mio_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [MIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [MIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system controller
  input wire logic expanded_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // analog port pins and converters
  input wire logic [MIO_AN_W-1:0] analog_pin_in,
  input wire logic [1:0] analog_out_request,
  output logic [MIO_AN_W-1:0] analog_levels_to_converter,
  output logic [1:0] analog_out_active,
  // serial-shared port pins
  input wire logic [MIO_SP_W-1:0] sp_pin_in,
  output logic [MIO_SP_W-1:0] sp_pin_out,
  output logic [MIO_SP_W-1:0] sp_pin_oe,
  // serial channel
  input wire logic serial_tx_enable,
  input wire logic serial_transmit_out,
  input wire logic serial_rx_enable,
  input wire logic serial_clk_enable,
  input wire logic serial_clk_drive,
  input wire logic serial_clk_out,
  output logic serial_receive_in,
  output logic serial_clock_pin,
  // interrupt inputs, read-view levels: latch for outputs, pin for inputs (active low)
  output logic ext_interrupt_three,
  output logic ext_interrupt_four,
  output logic ext_interrupt_five,
  output logic ext_interrupt_zero,
  output logic ext_interrupt_one,
  output logic ext_interrupt_two,
  output logic converter_trigger_in,
  // bus-control port pins
  input wire logic [MIO_BP_W-1:0] bp_pin_in,
  output logic [MIO_BP_W-1:0] bp_pin_out,
  output logic [MIO_BP_W-1:0] bp_pin_oe,
  // bus controller
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic address_strobe_n,
  input wire logic system_clock_level,
  output logic wait_in_n
);

  // pin synchronisers
  mio_sync_if #(.W(MIO_SYNC_W)) sync_bus ();
  mio_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(sync_bus.syncer)
  );
  assign sync_bus.raw = {bp_pin_in, sp_pin_in, analog_pin_in};

  logic [MIO_AN_W-1:0] an_lvl;
  logic [MIO_SP_W-1:0] sp_lvl;
  logic [MIO_BP_W-1:0] bp_lvl;
  assign an_lvl = sync_bus.synced[MIO_AN_W-1:0];
  assign sp_lvl = sync_bus.synced[MIO_AN_W+MIO_SP_W-1:MIO_AN_W];
  assign bp_lvl = sync_bus.synced[MIO_SYNC_W-1:MIO_AN_W+MIO_SP_W];

  // port registers
  logic [MIO_SP_W-1:0] sp_dir_reg;
  logic [MIO_SP_W-1:0] sp_data_reg;
  logic [MIO_BP_W-1:0] bp_dir_reg;
  logic [MIO_BP_W-1:0] bp_data_reg;

  // read views: latch for outputs, pin level for inputs
  logic [MIO_SP_W-1:0] sp_rd;
  logic [MIO_BP_W-1:0] bp_rd;
  genvar gi;
  generate
    for (gi = 0; gi < MIO_BP_W; gi++) begin : g_rd
      if (gi < MIO_SP_W) begin : g_sp
        assign sp_rd[gi] = sp_dir_reg[gi] ? sp_data_reg[gi] : sp_lvl[gi];
      end
      if (gi == MIO_BP_CLK_BIT) begin : g_clk
        // no latch behind this bit: it always shows the pin
        assign bp_rd[gi] = bp_lvl[gi];
      end else begin : g_gp
        assign bp_rd[gi] = bp_dir_reg[gi] ? bp_data_reg[gi] : bp_lvl[gi];
      end
    end
  endgenerate

  // ---------------- axi4-lite write path ----------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [MIO_ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic aw_take;
  logic w_take;
  logic wr_do;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_got_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else begin
      if (wr_do) begin
        aw_got_reg <= 1'b0;
      end
      s_axi_awready <= !aw_got_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got_reg <= 1'b0;
      w_byte_reg <= '0;
      w_lane_reg <= 1'b0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_got_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else begin
      if (wr_do) begin
        w_got_reg <= 1'b0;
      end
      s_axi_wready <= !w_got_reg && !s_axi_bvalid;
    end
  end

  logic wr_mapped;
  always_comb begin
    case (aw_addr_reg)
      MIO_ADDR_SP_DIR, MIO_ADDR_AN_LVL, MIO_ADDR_SP_DATA,
      MIO_ADDR_BP_DIR, MIO_ADDR_BP_DATA: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MIO_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? MIO_RESP_OKAY : MIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_do && w_lane_reg;

  // serial port direction and data survive software standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_dir_reg <= MIO_SP_DIR_RST[MIO_SP_W-1:0];
      sp_data_reg <= MIO_SP_DATA_RST[MIO_SP_W-1:0];
    end else if (wr_en) begin
      // reserved top bit is simply not stored
      if (aw_addr_reg == MIO_ADDR_SP_DIR) begin
        sp_dir_reg <= w_byte_reg[MIO_SP_W-1:0];
      end
      if (aw_addr_reg == MIO_ADDR_SP_DATA) begin
        sp_data_reg <= w_byte_reg[MIO_SP_W-1:0];
      end
    end
  end

  // sync reset lets the mode level pick the reset value directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_dir_reg <= expanded_mode ? MIO_BP_DIR_RST_EXP : MIO_BP_DIR_RST_SC;
      bp_data_reg <= MIO_BP_DATA_RST;
    end else if (wr_en) begin
      if (aw_addr_reg == MIO_ADDR_BP_DIR) begin
        bp_dir_reg <= w_byte_reg;
        // clock pin direction is fixed while expanded
        if (expanded_mode) begin
          bp_dir_reg[MIO_BP_CLK_BIT] <= bp_dir_reg[MIO_BP_CLK_BIT];
        end
      end
      if (aw_addr_reg == MIO_ADDR_BP_DATA) begin
        bp_data_reg <= w_byte_reg;
        bp_data_reg[MIO_BP_CLK_BIT] <= 1'b0;
      end
    end
  end

  // ---------------- axi4-lite read path ----------------
  logic ar_got_reg;
  logic [MIO_ADDR_W-1:0] ar_addr_reg;
  logic rd_do;
  assign rd_do = ar_got_reg && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      ar_got_reg <= 1'b0;
      ar_addr_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      ar_got_reg <= 1'b1;
      ar_addr_reg <= s_axi_araddr;
    end else begin
      if (rd_do) begin
        ar_got_reg <= 1'b0;
      end
      s_axi_arready <= !ar_got_reg && !s_axi_rvalid;
    end
  end

  logic [7:0] rd_byte;
  logic rd_mapped;
  always_comb begin
    rd_byte = '0;
    rd_mapped = 1'b1;
    case (ar_addr_reg)
      MIO_ADDR_SP_DIR: rd_byte = MIO_WO_READ_VAL;
      MIO_ADDR_AN_LVL: rd_byte = an_lvl;
      MIO_ADDR_SP_DATA: rd_byte = {1'b1, sp_rd};
      MIO_ADDR_BP_DIR: rd_byte = MIO_WO_READ_VAL;
      MIO_ADDR_BP_DATA: rd_byte = bp_rd;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= MIO_RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_mapped ? MIO_RESP_OKAY : MIO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- serial-shared pin drivers ----------------
  // software standby resets the serial channel, so its overrides drop away
  logic tx_use;
  logic rx_use;
  logic clk_use;
  assign tx_use = serial_tx_enable && !sw_standby;
  assign rx_use = serial_rx_enable && !sw_standby;
  assign clk_use = serial_clk_enable && !sw_standby;

  logic [MIO_SP_W-1:0] sp_oe_next;
  logic [MIO_SP_W-1:0] sp_out_next;
  always_comb begin
    sp_oe_next = sp_dir_reg;
    sp_out_next = sp_data_reg;
    if (tx_use) begin
      sp_oe_next[MIO_SP_TX_BIT] = 1'b1;
      sp_out_next[MIO_SP_TX_BIT] = serial_transmit_out;
    end
    if (rx_use) begin
      sp_oe_next[MIO_SP_RX_BIT] = 1'b0;
    end
    if (clk_use) begin
      sp_oe_next[MIO_SP_CLK_BIT] = serial_clk_drive;
      sp_out_next[MIO_SP_CLK_BIT] = serial_clk_out;
    end
    if (hw_standby) begin
      sp_oe_next = '0;
    end
  end

  // ---------------- bus-control pin drivers ----------------
  logic [MIO_BP_W-1:0] bp_oe_next;
  logic [MIO_BP_W-1:0] bp_out_next;
  always_comb begin
    bp_oe_next = bp_dir_reg;
    bp_out_next = bp_data_reg;
    bp_out_next[MIO_BP_CLK_BIT] = system_clock_level;
    if (expanded_mode) begin
      bp_oe_next[MIO_BP_AS_BIT:MIO_BP_RD_BIT] = 3'b111;
      bp_out_next[MIO_BP_RD_BIT] = read_strobe_n;
      bp_out_next[MIO_BP_WR_BIT] = write_strobe_n;
      bp_out_next[MIO_BP_AS_BIT] = address_strobe_n;
      bp_oe_next[MIO_BP_CLK_BIT] = 1'b1;
      bp_oe_next[MIO_BP_WAIT_BIT] = 1'b0;
      // strobes and clock hold high while the core sleeps
      if (sw_standby) begin
        bp_out_next[MIO_BP_CLK_BIT:MIO_BP_RD_BIT] = 4'hf;
      end
    end
    if (hw_standby) begin
      bp_oe_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_pin_oe <= '0;
      sp_pin_out <= '0;
      bp_pin_oe <= '0;
      bp_pin_out <= '0;
    end else begin
      sp_pin_oe <= sp_oe_next;
      sp_pin_out <= sp_out_next;
      bp_pin_oe <= bp_oe_next;
      bp_pin_out <= bp_out_next;
    end
  end

  // ---------------- function inputs toward other units ----------------
  // interrupt sources see the read view, so an output pin's latch can fire them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_interrupt_three <= 1'b1;
      ext_interrupt_four <= 1'b1;
      ext_interrupt_five <= 1'b1;
      ext_interrupt_two <= 1'b1;
      ext_interrupt_one <= 1'b1;
      ext_interrupt_zero <= 1'b1;
      converter_trigger_in <= 1'b1;
    end else begin
      ext_interrupt_three <= sp_rd[MIO_SP_TX_BIT];
      ext_interrupt_four <= sp_rd[MIO_SP_RX_BIT];
      ext_interrupt_five <= sp_rd[MIO_SP_CLK_BIT];
      ext_interrupt_two <= bp_rd[MIO_BP_TRIG_BIT];
      ext_interrupt_one <= bp_rd[MIO_BP_INT1_BIT];
      ext_interrupt_zero <= bp_rd[MIO_BP_INT0_BIT];
      converter_trigger_in <= bp_rd[MIO_BP_TRIG_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_receive_in <= 1'b1;
      serial_clock_pin <= 1'b1;
      wait_in_n <= 1'b1;
      analog_levels_to_converter <= '0;
      analog_out_active <= '0;
    end else begin
      serial_receive_in <= sp_lvl[MIO_SP_RX_BIT];
      serial_clock_pin <= sp_lvl[MIO_SP_CLK_BIT];
      wait_in_n <= expanded_mode ? bp_lvl[MIO_BP_WAIT_BIT] : 1'b1;
      analog_levels_to_converter <= an_lvl;
      analog_out_active <= analog_out_request;
    end
  end

  // ---------------- assertions ----------------
  a_analog_read_live: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_do && ar_addr_reg == MIO_ADDR_AN_LVL |=> s_axi_rdata[7:0] == $past(an_lvl))
    else $error("analog port read does not show pin levels");
  a_sp_read_mux: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_do && ar_addr_reg == MIO_ADDR_SP_DATA
    |=> s_axi_rdata[7:0] == {1'b1, $past(sp_rd)} && s_axi_rvalid)
    else $error("serial port data read wrong");
  a_tx_pin_owned: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_use && !hw_standby |=> sp_pin_oe[MIO_SP_TX_BIT]
    && sp_pin_out[MIO_SP_TX_BIT] == $past(serial_transmit_out))
    else $error("transmit pin not driven by serial channel");
  a_rx_pin_input: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_use |=> !sp_pin_oe[MIO_SP_RX_BIT])
    else $error("receive pin driven");
  a_hw_standby_float: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_standby |=> sp_pin_oe == '0 && bp_pin_oe == '0)
    else $error("pin driven in hardware standby");
  a_sw_standby_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_standby && !hw_standby |=> sp_pin_oe == $past(sp_dir_reg)
    && sp_pin_out == $past(sp_data_reg))
    else $error("serial pins not general io in software standby");
  a_sp_reset_inputs: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> sp_dir_reg == '0 ##1 sp_pin_oe == '0)
    else $error("serial port not inputs after reset");
  a_strobes_expanded: assert property (@(posedge aclk) disable iff (!aresetn)
    expanded_mode && !hw_standby && !sw_standby
    |=> bp_pin_oe[MIO_BP_AS_BIT:MIO_BP_RD_BIT] == 3'b111 && bp_pin_out[MIO_BP_AS_BIT:MIO_BP_RD_BIT]
    == $past({address_strobe_n, write_strobe_n, read_strobe_n}))
    else $error("bus strobes not driven in expanded mode");
  a_bp_dir_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> bp_dir_reg == ($past(expanded_mode) ? MIO_BP_DIR_RST_EXP : MIO_BP_DIR_RST_SC))
    else $error("bus port direction reset value wrong");
  a_clock_pin_sc: assert property (@(posedge aclk) disable iff (!aresetn)
    !expanded_mode && !hw_standby |=> bp_pin_oe[MIO_BP_CLK_BIT] == $past(bp_dir_reg[MIO_BP_CLK_BIT]))
    else $error("clock pin direction wrong in single-chip mode");
  a_wait_pin_input: assert property (@(posedge aclk) disable iff (!aresetn)
    expanded_mode |=> !bp_pin_oe[MIO_BP_WAIT_BIT])
    else $error("wait pin driven in expanded mode");
endmodule // mio_ports

// *** shared/mio_pkg.sv ***
// constants for the three general-purpose ports: offsets, reset values, bit positions
package mio_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] MIO_IDX_SP_DIR = 16'hffbd;
  localparam logic [15:0] MIO_IDX_AN_LVL = 16'hffbe;
  localparam logic [15:0] MIO_IDX_SP_DATA = 16'hffbf;
  localparam logic [15:0] MIO_IDX_BP_DIR = 16'hffc0;
  localparam logic [15:0] MIO_IDX_BP_DATA = 16'hffc1;
  localparam int MIO_ADDR_W = 18;
  localparam logic [MIO_ADDR_W-1:0] MIO_ADDR_SP_DIR = {MIO_IDX_SP_DIR, 2'b00};
  localparam logic [MIO_ADDR_W-1:0] MIO_ADDR_AN_LVL = {MIO_IDX_AN_LVL, 2'b00};
  localparam logic [MIO_ADDR_W-1:0] MIO_ADDR_SP_DATA = {MIO_IDX_SP_DATA, 2'b00};
  localparam logic [MIO_ADDR_W-1:0] MIO_ADDR_BP_DIR = {MIO_IDX_BP_DIR, 2'b00};
  localparam logic [MIO_ADDR_W-1:0] MIO_ADDR_BP_DATA = {MIO_IDX_BP_DATA, 2'b00};
  // reset values
  localparam logic [7:0] MIO_SP_DIR_RST = 8'h80;
  localparam logic [7:0] MIO_SP_DATA_RST = 8'h80;
  localparam logic [7:0] MIO_BP_DIR_RST_EXP = 8'h40;
  localparam logic [7:0] MIO_BP_DIR_RST_SC = 8'h00;
  localparam logic [7:0] MIO_BP_DATA_RST = 8'h00;
  localparam logic [7:0] MIO_WO_READ_VAL = 8'hff;
  // bit positions
  localparam int MIO_SP_RSV_BIT = 7;
  localparam int MIO_SP_TX_BIT = 4;
  localparam int MIO_SP_RX_BIT = 5;
  localparam int MIO_SP_CLK_BIT = 6;
  localparam int MIO_BP_TRIG_BIT = 0;
  localparam int MIO_BP_INT1_BIT = 1;
  localparam int MIO_BP_INT0_BIT = 2;
  localparam int MIO_BP_RD_BIT = 3;
  localparam int MIO_BP_WR_BIT = 4;
  localparam int MIO_BP_AS_BIT = 5;
  localparam int MIO_BP_CLK_BIT = 6;
  localparam int MIO_BP_WAIT_BIT = 7;
  // pin widths and synchroniser layout
  localparam int MIO_AN_W = 8;
  localparam int MIO_SP_W = 7;
  localparam int MIO_BP_W = 8;
  localparam int MIO_SYNC_W = MIO_AN_W + MIO_SP_W + MIO_BP_W;
  // bus responses
  localparam logic [1:0] MIO_RESP_OKAY = 2'b00;
  localparam logic [1:0] MIO_RESP_SLVERR = 2'b10;
endpackage

// *** shared/mio_sync_if.sv ***
// carrier between the port block and its pin synchroniser
`timescale 1ns/1ps
interface mio_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport user (output raw, input synced);
  modport syncer (input raw, output synced);
endinterface

// *** hdl/mio_pin_sync.sv ***
// two-flop synchroniser for all pin inputs of the port block
`timescale 1ns/1ps
module mio_pin_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins in, synchronised levels out
  mio_sync_if.syncer port
);
  logic [$bits(port.raw)-1:0] meta_reg;
  logic [$bits(port.raw)-1:0] sync_reg;

  // first stage feeds only the second stage
  // idle-high reset: active-low interrupt and receive lines see no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= port.raw;
      sync_reg <= meta_reg;
    end
  end

  assign port.synced = sync_reg;
endmodule // mio_pin_sync

// *** testbench/mio_pin_board.sv ***
// board model: external levels on the general-purpose pins of the port block
`timescale 1ns/1ps
module mio_pin_board import mio_pkg::*; (
  // pins from the port block
  input wire logic [MIO_SP_W-1:0] sp_pin_out,
  input wire logic [MIO_SP_W-1:0] sp_pin_oe,
  input wire logic [MIO_BP_W-1:0] bp_pin_out,
  input wire logic [MIO_BP_W-1:0] bp_pin_oe,
  // levels the board drives where the block does not
  input wire logic [MIO_AN_W-1:0] an_ext,
  input wire logic [MIO_SP_W-1:0] sp_ext,
  input wire logic [MIO_BP_W-1:0] bp_ext,
  // resolved pin levels back to the block
  output logic [MIO_AN_W-1:0] analog_pin_in,
  output logic [MIO_SP_W-1:0] sp_pin_in,
  output logic [MIO_BP_W-1:0] bp_pin_in
);
  // analog pins are never driven by the block
  assign analog_pin_in = an_ext;
  // a driven pin shows the block's level, an undriven one the board's
  assign sp_pin_in = (sp_pin_oe & sp_pin_out) | (~sp_pin_oe & sp_ext);
  assign bp_pin_in = (bp_pin_oe & bp_pin_out) | (~bp_pin_oe & bp_ext);
endmodule // mio_pin_board

// *** testbench/test_mio_ports.sv ***
// self-checking bench for the three general-purpose ports
`timescale 1ns/1ps
module test_mio_ports import mio_pkg::*; ();
  logic aclk, aresetn;
  logic [MIO_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ao_req, ao_act;
  logic expanded_mode, hw_standby, sw_standby;
  logic [7:0] an_ext, an_pin, an_conv, bp_ext, bp_in, bp_out, bp_oe;
  logic [6:0] sp_ext, sp_in, sp_out, sp_oe;
  logic tx_en, tx_d, rx_en, ck_en, ck_drv, ck_out, rx_pin, ck_pin, wait_n;
  logic ei_three, ei_four, ei_five, ei_zero, ei_one, ei_two, trig_in;
  logic rd_n, wr_n, as_n, sys_ck;
  int failures, n_tests, cyc;

  mio_ports mio_ports_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .expanded_mode(expanded_mode), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .analog_pin_in(an_pin), .analog_out_request(ao_req),
    .analog_levels_to_converter(an_conv), .analog_out_active(ao_act),
    .sp_pin_in(sp_in), .sp_pin_out(sp_out), .sp_pin_oe(sp_oe),
    .serial_tx_enable(tx_en), .serial_transmit_out(tx_d), .serial_rx_enable(rx_en),
    .serial_clk_enable(ck_en), .serial_clk_drive(ck_drv), .serial_clk_out(ck_out),
    .serial_receive_in(rx_pin), .serial_clock_pin(ck_pin),
    .ext_interrupt_three(ei_three), .ext_interrupt_four(ei_four),
    .ext_interrupt_five(ei_five), .ext_interrupt_zero(ei_zero),
    .ext_interrupt_one(ei_one), .ext_interrupt_two(ei_two),
    .converter_trigger_in(trig_in),
    .bp_pin_in(bp_in), .bp_pin_out(bp_out), .bp_pin_oe(bp_oe),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .address_strobe_n(as_n),
    .system_clock_level(sys_ck), .wait_in_n(wait_n)
  );

  mio_pin_board mio_pin_board_i (
    .sp_pin_out(sp_out), .sp_pin_oe(sp_oe), .bp_pin_out(bp_out), .bp_pin_oe(bp_oe),
    .an_ext(an_ext), .sp_ext(sp_ext), .bp_ext(bp_ext),
    .analog_pin_in(an_pin), .sp_pin_in(sp_in), .bp_pin_in(bp_in)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [MIO_ADDR_W-1:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 32'h0000_0000, 32'(bresp));
  endtask

  task automatic rd(input string what, input logic [MIO_ADDR_W-1:0] a,
                    input logic [7:0] exp, input logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(what, {24'h00_0000, exp}, rdata);
    chk("rresp", 32'(resp), 32'(rresp));
  endtask

  // pins pass a pin register, two sync flops and an output register; look one edge later
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask

  task automatic rst(input logic mode);
    expanded_mode <= mode;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    expanded_mode = 1'b0;
    hw_standby = 1'b0;
    sw_standby = 1'b0;
    ao_req = 2'b00;
    {tx_en, tx_d, rx_en, ck_en, ck_drv, ck_out} = 6'h00;
    {rd_n, wr_n, as_n, sys_ck} = 4'b1011;
    an_ext = 8'h5c;
    sp_ext = 7'h2a;
    bp_ext = 8'h96;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    rst(1'b0);
    rd("analog", MIO_ADDR_AN_LVL, 8'h5c, MIO_RESP_OKAY);
    rd("sp dir", MIO_ADDR_SP_DIR, MIO_WO_READ_VAL, MIO_RESP_OKAY);
    rd("sp data", MIO_ADDR_SP_DATA, 8'haa, MIO_RESP_OKAY);
    chk("sp oe", 32'h0000_0000, 32'(sp_oe));
    chk("bp oe", 32'h0000_0000, 32'(bp_oe));
    rd("bp data", MIO_ADDR_BP_DATA, 8'h96, MIO_RESP_OKAY);
    chk("int lines", 32'h0000_000c, 32'({ei_zero, ei_one, trig_in, ei_two}));
    // interrupt-capable pins 4 to 6 stay inputs
    wr(MIO_ADDR_SP_DIR, 8'h0f);
    wr(MIO_ADDR_SP_DATA, 8'h05);
    settle;
    rd("sp mixed", MIO_ADDR_SP_DATA, 8'ha5, MIO_RESP_OKAY);
    chk("sp oe", 32'h0000_000f, 32'(sp_oe));
    chk("sp out", 32'h0000_0005, 32'(sp_out[3:0]));
    chk("int three", 32'h0000_0000, 32'(ei_three));
    chk("int four five", 32'h0000_0001, 32'({ei_five, ei_four}));
    wr(MIO_ADDR_SP_DATA, 8'h00);
    // a write with lane zero off must leave the latch alone
    wstrb <= 4'h0;
    wr(MIO_ADDR_SP_DATA, 8'h0f);
    wstrb <= 4'hf;
    rd("sp top", MIO_ADDR_SP_DATA, 8'ha0, MIO_RESP_OKAY);
    wr(MIO_ADDR_AN_LVL, 8'hff);
    rd("analog ro", MIO_ADDR_AN_LVL, 8'h5c, MIO_RESP_OKAY);
    rd("unmapped", 18'h0_0000, 8'h00, MIO_RESP_SLVERR);
    ao_req <= 2'b10;
    settle;
    chk("dac", 32'h0000_0002, 32'(ao_act));
    chk("adc", 32'h0000_005c, 32'(an_conv));
    hw_standby <= 1'b1;
    settle;
    chk("hw stby", 32'h0000_0000, 32'(sp_oe));
    hw_standby <= 1'b0;
    {tx_en, tx_d, rx_en, ck_en, ck_drv, ck_out} <= 6'b111111;
    settle;
    chk("serial oe", 32'h0000_005f, 32'(sp_oe));
    chk("serial out", 32'h0000_0050, 32'(sp_out & 7'h50));
    chk("clk pin", 32'h0000_0001, 32'(ck_pin));
    chk("rx", 32'h0000_0001, 32'(rx_pin));
    sw_standby <= 1'b1;
    settle;
    chk("sw stby", 32'h0000_000f, 32'(sp_oe));
    sw_standby <= 1'b0;
    {tx_en, tx_d, rx_en, ck_en, ck_drv, ck_out} <= 6'h00;
    wr(MIO_ADDR_BP_DIR, 8'h41);
    wr(MIO_ADDR_BP_DATA, 8'h01);
    settle;
    chk("bp oe sc", 32'h0000_0041, 32'(bp_oe));
    rd("bp data sc", MIO_ADDR_BP_DATA, 8'hd7, MIO_RESP_OKAY);
    chk("int latch", 32'h0000_000f, 32'({ei_zero, ei_one, trig_in, ei_two}));
    rst(1'b1);
    chk("bp oe exp", 32'h0000_0078, 32'(bp_oe));
    chk("strobes", 32'h0000_0068, 32'(bp_out & 8'h78));
    chk("wait", 32'h0000_0001, 32'(wait_n));
    wr(MIO_ADDR_BP_DIR, 8'h00);
    wr(MIO_ADDR_BP_DATA, 8'h00);
    settle;
    chk("bp oe fixed", 32'h0000_0078, 32'(bp_oe));
    // sleeping core: strobes and clock held high; wait pin pulled low by the board
    sw_standby <= 1'b1;
    bp_ext <= 8'h16;
    settle;
    chk("stby strobes", 32'h0000_0078, 32'(bp_out & 8'h78));
    chk("wait low", 32'h0000_0000, 32'(wait_n));
    end_of_test();
  end
endmodule // test_mio_ports
